/* File: verilog/dtam_pkg.sv */
// Purpose: Shared constants and types for the debug transfer access-mode block
// Assumes: One 250 MHz clock, active-low asynchronous reset
// Notes:   Bit positions refer to the debug status and control word
package dtam_pkg;

  // ==========================================================
  // Widths and depths
  localparam int DTAM_DATA_W = 32;
  localparam int DTAM_FIFO_DEPTH = 8;

  // ==========================================================
  // Status and control word bit positions
  localparam int DTAM_BIT_RX_FULL = 30;
  localparam int DTAM_BIT_TX_FULL = 29;
  localparam int DTAM_BIT_LAT_RX = 27;
  localparam int DTAM_BIT_LAT_TX = 26;
  localparam int DTAM_BIT_LAT_IC = 24;
  localparam int DTAM_BIT_MODE_HI = 21;
  localparam int DTAM_BIT_MODE_LO = 20;
  localparam int DTAM_BIT_EXEC_EN = 13;
  localparam int DTAM_BIT_PABORT = 6;

  // ==========================================================
  // Access modes and register selects
  typedef enum logic [1:0] {
    DTAM_MODE_NONBLOCK = 2'h0,
    DTAM_MODE_STALL = 2'h1,
    DTAM_MODE_FAST = 2'h2,
    DTAM_MODE_RSVD = 2'h3
  } dtam_mode_type;

  typedef enum logic [1:0] {
    DTAM_SEL_STATUS = 2'h0,
    DTAM_SEL_RX = 2'h1,
    DTAM_SEL_TX = 2'h2,
    DTAM_SEL_ITR = 2'h3
  } dtam_sel_type;

  // ==========================================================
  // Reset values
  localparam dtam_mode_type DTAM_MODE_RESET = DTAM_MODE_NONBLOCK;
  localparam logic DTAM_EXEC_EN_RESET = 1'b0;
  localparam logic DTAM_IC_RESET = 1'b1;
  localparam logic DTAM_FULL_RESET = 1'b0;
  localparam logic [31:0] DTAM_WORD_RESET = 32'h0000_0000;

endpackage

/* File: verilog/dtam_fifo_if.sv */
// Purpose: Valid/ready carrier between the access logic and its instruction FIFO
// Assumes: Same clock on both sides
// Notes:   Push side filled by the access logic, pop side drains to the core
`timescale 1ns/10ps
`default_nettype none
interface dtam_fifo_if #(
  parameter int WIDTH = 32
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo (input push_valid, input push_data, output push_ready,
                output pop_valid, output pop_data, input pop_ready);
  modport user (output push_valid, output push_data, input push_ready,
                input pop_valid, input pop_data, output pop_ready);
endinterface
`default_nettype wire

/* File: verilog/dtam_fifo.sv */
// Purpose: Flip-flop FIFO holding instructions on their way to the core
// Assumes: DEPTH is a power of two, at least two
// Notes:   Full drops push_ready, which stalls the external access that issues
`timescale 1ns/10ps
`default_nettype none
module dtam_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock,      // Core debug clock
  input wire logic arst_n,     // Async reset, active low
  dtam_fifo_if.fifo port_if    // Push and pop sides
);
  import dtam_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Elaboration check
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dtam_fifo: DEPTH must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_push, do_pop;

  // Honest flags from the occupancy count
  assign port_if.push_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign port_if.pop_valid = (cnt_reg != '0);
  assign port_if.pop_data = mem_reg[rd_reg];
  assign do_push = port_if.push_valid && port_if.push_ready;
  assign do_pop = port_if.pop_valid && port_if.pop_ready;

  // ==========================================================
  // Next state
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (do_push) begin
      mem_next[wr_reg] = port_if.push_data;
      wr_next = wr_reg + AW'(1);
    end
    if (do_pop) begin
      rd_next = rd_reg + AW'(1);
    end
    if (do_push && !do_pop) begin
      cnt_next = cnt_reg + (AW+1)'(1);
    end else if (!do_push && do_pop) begin
      cnt_next = cnt_reg - (AW+1)'(1);
    end
  end

  // Registers only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/dtam_access.sv */
// Purpose: Access-mode control of the debug transfer and instruction registers
// Assumes: External access port and core signals all on the core debug clock
// Notes:   One external request at a time; a held request blocks every register
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Two-bit mode field: nonblock, stall, fast, reserved
// - Mode resets to non-blocking
// - Mode affects external transfer accesses only
// - Non-blocking ignores receive write when latched full
// - Non-blocking ignores instruction write when latched incomplete
// - Non-blocking ignores transmit read when latched empty
// - Accepted receive write sets full and latched
// - Accepted transmit read clears full and latched
// - Accepted instruction write clears complete and latched
// - Software lock read-only; OS lock errors
// - Stall mode holds access until channel ready
// - Pending stalled access blocks all registers
// - Stall/fast skip ignores, update flags normally
// - Fast mode latches instruction write, waits complete
// - Fast receive write stores data then issues
// - Fast transmit read returns data then issues
// - Fast with precise abort completes without issue
// - Complete cleared on issue, set on done/entry
// - Latched complete at bit 24, copied on read
// - Latched receive bit 27, transmit bit 26
// - Transmit full bit 29, core sets, read clears
// - Receive full bit 30, external sets, core clears
module dtam_access #(
  parameter int DEPTH = dtam_pkg::DTAM_FIFO_DEPTH
) (
  input wire logic clock,                          // Core debug clock, 250 MHz
  input wire logic arst_n,                         // Async reset, active low
  input wire logic ext_req,                        // External request, held until ack
  input wire logic ext_write,                      // 1 write, 0 read
  input wire dtam_pkg::dtam_sel_type ext_sel,      // Register selected
  input wire logic ext_via_mem,                    // Memory-mapped path, else debug port
  input wire logic [31:0] ext_wdata,               // Write data
  output logic ext_ack,                            // Access done, one-cycle pulse
  output logic ext_err,                            // Error answer, with ack
  output logic [31:0] ext_rdata,                   // Read data, valid with ack
  input wire logic soft_lock,                      // Software lock set
  input wire logic os_lock,                        // OS lock set
  input wire logic sticky_pdown,                   // Sticky power-down flag
  input wire logic precise_abort,                  // Sticky precise abort
  input wire logic debug_entry,                    // Debug state entered, pulse
  input wire logic int_rx_rd,                      // Core reads receive reg, pulse
  output logic [31:0] int_rx_data,                 // Receive data to core
  input wire logic int_tx_wr,                      // Core writes transmit reg, pulse
  input wire logic [31:0] int_tx_wdata,            // Transmit data from core
  output logic core_instr_valid,                   // Instruction ready for core
  input wire logic core_instr_ready,               // Core takes instruction
  output logic [31:0] core_instr_data,             // Instruction word
  input wire logic core_instr_done,                // Issued instruction finished, pulse
  output logic exec_enable                         // Execute-instruction enable bit
);
  import dtam_pkg::*;

  // Elaboration check: the queue needs two entries at least
  if (DEPTH < 2) begin : g_bad_depth
    $error("dtam_access: DEPTH must be at least two");
  end

  // Instruction queue between the access port and the core
  dtam_fifo_if #(.WIDTH(DTAM_DATA_W)) ififo ();

  dtam_fifo #(.WIDTH(DTAM_DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .port_if(ififo)
  );

  // ==========================================================
  // Core side of the instruction queue
  assign core_instr_valid = ififo.pop_valid;
  assign core_instr_data = ififo.pop_data;
  assign ififo.pop_ready = core_instr_ready;

  // ==========================================================
  // State
  // Mode field and execute enable
  dtam_mode_type mode_reg;
  dtam_mode_type mode_next;
  logic exec_reg;
  logic exec_next;
  // Live full flags and their latched copies
  logic rx_full_reg;
  logic rx_full_next;
  logic tx_full_reg;
  logic tx_full_next;
  logic lat_rx_reg;
  logic lat_rx_next;
  logic lat_tx_reg;
  logic lat_tx_next;
  // Instruction complete, live and latched
  logic ic_reg;
  logic ic_next;
  logic lat_ic_reg;
  logic lat_ic_next;
  // Data words held for both sides
  logic [31:0] rx_data_reg;
  logic [31:0] rx_data_next;
  logic [31:0] tx_data_reg;
  logic [31:0] tx_data_next;
  logic [31:0] itr_reg;
  logic [31:0] itr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Answer pulse and error flag
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;

  // Decode
  dtam_mode_type mode_eff;
  logic is_xfer;
  logic lock_err;
  logic ro_block;
  logic wr_rx;
  logic wr_itr;
  logic rd_tx;
  logic rd_status;
  logic wr_status;
  // Take control and instruction push request
  logic can_go;
  logic do_xfer;
  logic issue;
  logic take;
  logic [31:0] status_word;

  // Live status word; latched bits read back the live flags
  always_comb begin
    status_word = DTAM_WORD_RESET;
    status_word[DTAM_BIT_RX_FULL] = rx_full_reg;
    status_word[DTAM_BIT_TX_FULL] = tx_full_reg;
    status_word[DTAM_BIT_LAT_RX] = rx_full_reg;
    status_word[DTAM_BIT_LAT_TX] = tx_full_reg;
    status_word[DTAM_BIT_LAT_IC] = ic_reg;
    status_word[DTAM_BIT_MODE_HI:DTAM_BIT_MODE_LO] = mode_reg;
    status_word[DTAM_BIT_EXEC_EN] = exec_reg;
    status_word[DTAM_BIT_PABORT] = precise_abort;
  end

  // ==========================================================
  // Access decision
  // Reserved code falls back to non-blocking so it cannot deadlock the port
  always_comb begin
    mode_eff = (mode_reg == DTAM_MODE_RSVD) ? DTAM_MODE_NONBLOCK : mode_reg;
    is_xfer = (ext_sel != DTAM_SEL_STATUS);
    // Locks: error on the debug port, read-only over memory
    lock_err = is_xfer && !ext_via_mem && (os_lock || sticky_pdown);
    ro_block = ext_via_mem && soft_lock && ext_write && is_xfer;
    // Register and direction
    wr_rx = ext_write && (ext_sel == DTAM_SEL_RX);
    wr_itr = ext_write && (ext_sel == DTAM_SEL_ITR);
    rd_tx = !ext_write && (ext_sel == DTAM_SEL_TX);
    rd_status = !ext_write && (ext_sel == DTAM_SEL_STATUS);
    wr_status = ext_write && (ext_sel == DTAM_SEL_STATUS);
    // Defaults: go at once, no transfer, no push
    can_go = 1'b1;
    do_xfer = 1'b0;
    issue = 1'b0;
    if (!(lock_err || ro_block)) begin
      unique case (mode_eff)
        // Stall: hold the take until the channel is ready
        DTAM_MODE_STALL: begin
          do_xfer = 1'b1;
          if (wr_rx) begin
            can_go = !rx_full_reg;
          end else if (wr_itr) begin
            can_go = ic_reg && ififo.push_ready;
            issue = 1'b1;
          end else if (rd_tx) begin
            can_go = tx_full_reg;
          end
        end
        // Fast: an instruction write only latches the word
        DTAM_MODE_FAST: begin
          do_xfer = 1'b1;
          if (wr_itr) begin
            can_go = ic_reg;
          end else if ((wr_rx || rd_tx) && !precise_abort) begin
            can_go = ic_reg && ififo.push_ready;
            issue = 1'b1;
          end
        end
        // Non-blocking: latched flags decide; every access acked except an instruction write while the queue is full
        default: begin
          if (wr_rx) begin
            do_xfer = !lat_rx_reg;
          end else if (wr_itr) begin
            do_xfer = lat_ic_reg;
            can_go = ififo.push_ready;
            issue = lat_ic_reg;
          end else if (rd_tx) begin
            do_xfer = lat_tx_reg;
          end else begin
            do_xfer = 1'b1;
          end
        end
      endcase
    end
    // Held request blocks the single port, so nothing else gets in
    take = ext_req && !ack_reg && can_go;
  end

  // Instruction push: fast mode re-issues the latched word
  assign ififo.push_valid = take && issue;
  assign ififo.push_data = (mode_eff == DTAM_MODE_FAST) ? itr_reg : ext_wdata;

  // ==========================================================
  // Next values of flags and data
  always_comb begin
    mode_next = mode_reg;
    exec_next = exec_reg;
    rx_full_next = rx_full_reg;
    tx_full_next = tx_full_reg;
    lat_rx_next = lat_rx_reg;
    lat_tx_next = lat_tx_reg;
    ic_next = ic_reg;
    lat_ic_next = lat_ic_reg;
    rx_data_next = rx_data_reg;
    tx_data_next = tx_data_reg;
    itr_next = itr_reg;
    rdata_next = rdata_reg;
    // One-cycle answer for every take
    ack_next = take;
    err_next = take && lock_err;
    // Core-side clears first so that external sets win
    if (int_rx_rd) begin
      rx_full_next = 1'b0;
    end

    // Debugger empties transmit; an ignored read keeps it
    if (take && do_xfer && rd_tx) begin
      tx_full_next = 1'b0;
      lat_tx_next = 1'b0;
    end

    // Issue clears complete until the core reports done
    if (take && issue) begin
      ic_next = 1'b0;
      lat_ic_next = 1'b0;
    end

    // Core write fills transmit and wins over a same-cycle read
    if (int_tx_wr) begin
      tx_full_next = 1'b1;
      tx_data_next = int_tx_wdata;
    end

    // Done or debug entry sets complete; set wins over issue
    if (core_instr_done || debug_entry) begin
      ic_next = 1'b1;
    end

    // Accepted receive write fills the channel
    if (take && do_xfer && wr_rx) begin
      rx_data_next = ext_wdata;
      rx_full_next = 1'b1;
      lat_rx_next = 1'b1;
    end

    // Instruction word latched in every mode
    if (take && do_xfer && wr_itr) begin
      itr_next = ext_wdata;
    end

    // Status write sets mode and execute enable
    if (take && wr_status && !ro_block) begin
      mode_next = dtam_mode_type'(ext_wdata[DTAM_BIT_MODE_HI:DTAM_BIT_MODE_LO]);
      exec_next = ext_wdata[DTAM_BIT_EXEC_EN];
    end

    // Status read copies the live flags into the latches
    if (take && rd_status) begin
      lat_rx_next = rx_full_reg;
      lat_tx_next = tx_full_reg;
      lat_ic_next = ic_reg;
    end
    // Read data captured at take; fast transmit read returns the old word
    if (take && !ext_write) begin
      unique case (ext_sel)
        DTAM_SEL_STATUS: rdata_next = status_word;
        DTAM_SEL_TX: rdata_next = lock_err ? DTAM_WORD_RESET : tx_data_reg;
        DTAM_SEL_RX: rdata_next = rx_data_reg;
        DTAM_SEL_ITR: rdata_next = itr_reg;
      endcase
    end
  end

  // ==========================================================
  // Registers only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // Non-blocking, channels empty, complete set
      mode_reg <= DTAM_MODE_RESET;
      exec_reg <= DTAM_EXEC_EN_RESET;
      rx_full_reg <= DTAM_FULL_RESET;
      tx_full_reg <= DTAM_FULL_RESET;
      lat_rx_reg <= DTAM_FULL_RESET;
      lat_tx_reg <= DTAM_FULL_RESET;
      ic_reg <= DTAM_IC_RESET;
      lat_ic_reg <= DTAM_IC_RESET;
      rx_data_reg <= DTAM_WORD_RESET;
      tx_data_reg <= DTAM_WORD_RESET;
      itr_reg <= DTAM_WORD_RESET;
      rdata_reg <= DTAM_WORD_RESET;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      // Next values come from the blocks above
      mode_reg <= mode_next;
      exec_reg <= exec_next;
      rx_full_reg <= rx_full_next;
      tx_full_reg <= tx_full_next;
      lat_rx_reg <= lat_rx_next;
      lat_tx_reg <= lat_tx_next;
      ic_reg <= ic_next;
      lat_ic_reg <= lat_ic_next;
      rx_data_reg <= rx_data_next;
      tx_data_reg <= tx_data_next;
      itr_reg <= itr_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  // Outputs straight from flops
  assign ext_ack = ack_reg;
  assign ext_err = err_reg;
  assign ext_rdata = rdata_reg;
  assign int_rx_data = rx_data_reg;
  assign exec_enable = exec_reg;
endmodule
`default_nettype wire

/* File: dv/dtam_access_checker.sv */
// Purpose: Port-level checks of the debug transfer access block
// Assumes: One clock, async active-low reset
// Notes:   Mode is not visible here, so checks stay mode-free
`timescale 1ns/10ps
`default_nettype none
module dtam_access_checker (
  input wire logic clock, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic ext_req, // Request
  input wire logic ext_write, // Write flag
  input wire dtam_pkg::dtam_sel_type ext_sel, // Register select
  input wire logic ext_via_mem, // Memory path
  input wire logic ext_ack, // Done pulse
  input wire logic ext_err, // Error answer
  input wire logic [31:0] ext_rdata, // Read data
  input wire logic os_lock, // OS lock
  input wire logic sticky_pdown, // Power-down flag
  input wire logic [31:0] int_rx_data, // Receive data
  input wire logic core_instr_valid, // Issue valid
  input wire logic exec_enable // Execute enable
);
  import dtam_pkg::*;
  // ==========================================================
  // Handshake and data-source checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_ack_pulse: assert property (ext_ack |=> !ext_ack)
    else $error("ack held over one cycle");
  a_ack_has_req: assert property (ext_ack |-> $past(ext_req))
    else $error("ack without request");
  a_err_cause: assert property (ext_err |-> $past(!ext_via_mem && (os_lock || sticky_pdown)))
    else $error("error answer without lock");
  // Locked debug-port transfer access answers at once
  a_lock_err: assert property (ext_req && !ext_ack && !ext_via_mem && (os_lock || sticky_pdown)
    && ext_sel inside {DTAM_SEL_RX, DTAM_SEL_TX} |=> ext_ack && ext_err)
    else $error("locked access not refused");
  a_rx_data_src: assert property ($changed(int_rx_data) |->
    $past(ext_req && ext_write && ext_sel == DTAM_SEL_RX))
    else $error("receive data moved without write");
  a_exec_src: assert property ($changed(exec_enable) |->
    $past(ext_req && ext_write && ext_sel == DTAM_SEL_STATUS))
    else $error("execute enable moved without write");
  a_rdata_src: assert property ($changed(ext_rdata) |-> ext_ack)
    else $error("read data moved outside ack");
  a_issue_src: assert property ($rose(core_instr_valid) |-> $past(ext_req))
    else $error("issue without external access");
endmodule
`default_nettype wire

/* File: dv/dtam_dbg_model.sv */
// Purpose: External debugger model driving the access port
// Assumes: Access answered by a one-cycle ack
// Notes:   Released write data is inverted so stale values never pass
`timescale 1ns/10ps
`default_nettype none
module dtam_dbg_model (
  input wire logic clock, // Core clock
  input wire logic ext_ack, // Done pulse
  input wire logic ext_err, // Error answer
  input wire logic [31:0] ext_rdata, // Read data
  output logic ext_req, // Request
  output logic ext_write, // Write flag
  output var dtam_pkg::dtam_sel_type ext_sel, // Register select
  output logic ext_via_mem, // Memory path
  output logic [31:0] ext_wdata // Write data
);
  import dtam_pkg::*;
  // ==========================================================
  // Idle bus at time zero
  initial begin
    ext_req = 1'b0;
    ext_write = 1'b0;
    ext_sel = DTAM_SEL_STATUS;
    ext_via_mem = 1'b0;
    ext_wdata = 32'h0;
  end
  // One access at a time, held until the ack edge
  task automatic acc(input logic w, input dtam_sel_type s, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clock);
    #1;
    ext_req = 1'b1;
    ext_write = w;
    ext_sel = s;
    ext_wdata = d;
    q = 'x;
    e = 1'bx;
    // A stall may hold the take long; the bench timeout ends a hang
    do begin
      @(posedge clock);
    end while (ext_ack !== 1'b1);
    q = ext_rdata;
    e = ext_err;
    #1;
    ext_req = 1'b0;
    ext_wdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: dv/dtam_access_tb.sv */
// Purpose: Self-checking bench for the access-mode block
// Assumes: Core side driven here, debugger side by the model
// Notes:   Core always takes instructions; pops are counted
`timescale 1ns/10ps
`default_nettype none
module dtam_access_tb;
  import dtam_pkg::*;
  logic clock, arst_n, ext_req, ext_write, ext_via_mem, ext_ack, ext_err;
  logic soft_lock, os_lock, sticky_pdown, precise_abort, debug_entry;
  logic int_rx_rd, int_tx_wr, core_instr_valid, core_instr_ready, core_instr_done;
  logic exec_enable, e;
  logic [31:0] ext_wdata, ext_rdata, int_rx_data, int_tx_wdata, core_instr_data, q, last_ins;
  dtam_sel_type ext_sel;
  int n_errors = 0, comparisons = 0, cycles = 0, pops = 0, p0;
  dtam_access u_dut (.clock(clock), .arst_n(arst_n), .ext_req(ext_req),
    .ext_write(ext_write), .ext_sel(ext_sel), .ext_via_mem(ext_via_mem),
    .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_err(ext_err), .ext_rdata(ext_rdata),
    .soft_lock(soft_lock), .os_lock(os_lock), .sticky_pdown(sticky_pdown),
    .precise_abort(precise_abort), .debug_entry(debug_entry), .int_rx_rd(int_rx_rd),
    .int_rx_data(int_rx_data), .int_tx_wr(int_tx_wr), .int_tx_wdata(int_tx_wdata),
    .core_instr_valid(core_instr_valid), .core_instr_ready(core_instr_ready),
    .core_instr_data(core_instr_data), .core_instr_done(core_instr_done),
    .exec_enable(exec_enable));
  dtam_dbg_model u_dbg (.clock(clock), .ext_ack(ext_ack), .ext_err(ext_err),
    .ext_rdata(ext_rdata), .ext_req(ext_req), .ext_write(ext_write), .ext_sel(ext_sel),
    .ext_via_mem(ext_via_mem), .ext_wdata(ext_wdata));
  // ==========================================================
  // Clock, pop counter and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (core_instr_valid === 1'b1) begin
      pops <= pops + 1;
      last_ins <= core_instr_data;
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("Error at %0t: run hung", $time);
      tally_and_finish();
    end
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input dtam_sel_type s, input logic [31:0] d);
    u_dbg.acc(1'b1, s, d, q, e);
  endtask
  task automatic rd(input dtam_sel_type s);
    u_dbg.acc(1'b0, s, 32'h0, q, e);
  endtask
  task automatic st(input logic [31:0] exp);
    rd(DTAM_SEL_STATUS);
    chk(q, exp);
  endtask
  // Core-side pulse: entry, receive read, transmit write, done
  task automatic ev(input logic [3:0] m);
    @(posedge clock);
    #1 {debug_entry, int_rx_rd, int_tx_wr, core_instr_done} = m;
    @(posedge clock);
    #1 {debug_entry, int_rx_rd, int_tx_wr, core_instr_done} = 4'h0;
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {soft_lock, os_lock, sticky_pdown, precise_abort} = 4'h0;
    {debug_entry, int_rx_rd, int_tx_wr, core_instr_done} = 4'h0;
    int_tx_wdata = 32'h0;
    core_instr_ready = 1'b1;
    repeat (2) @(posedge clock);
    #1 arst_n = 1'b1;
    st(32'h0100_0000);
    wr(DTAM_SEL_RX, 32'ha5a5_0001);
    chk(int_rx_data, 32'ha5a5_0001);
    wr(DTAM_SEL_RX, 32'h5a5a_0002);
    chk(int_rx_data, 32'ha5a5_0001);
    st(32'h4900_0000);
    ev(4'h4);
    st(32'h0100_0000);
    int_tx_wdata = 32'h1234_0003;
    ev(4'h2);
    rd(DTAM_SEL_TX);
    st(32'h2500_0000);
    rd(DTAM_SEL_TX);
    chk(q, 32'h1234_0003);
    st(32'h0100_0000);
    // Non-blocking instruction issue and refusal
    p0 = pops;
    wr(DTAM_SEL_ITR, 32'hc0de_0004);
    repeat (2) @(posedge clock);
    chk(last_ins, 32'hc0de_0004);
    st(32'h0000_0000);
    wr(DTAM_SEL_ITR, 32'hc0de_0005);
    repeat (2) @(posedge clock);
    chk(32'(pops - p0), 32'h1);
    ev(4'h1);
    st(32'h0100_0000);
    // Lock answers leave flags alone
    os_lock = 1'b1;
    wr(DTAM_SEL_RX, 32'hdead_0006);
    chk({31'h0, e}, 32'h1);
    os_lock = 1'b0;
    sticky_pdown = 1'b1;
    rd(DTAM_SEL_TX);
    chk({31'h0, e}, 32'h1);
    sticky_pdown = 1'b0;
    soft_lock = 1'b1;
    u_dbg.ext_via_mem = 1'b1;
    wr(DTAM_SEL_RX, 32'hdead_0007);
    chk({31'h0, e}, 32'h0);
    chk(int_rx_data, 32'ha5a5_0001);
    soft_lock = 1'b0;
    u_dbg.ext_via_mem = 1'b0;
    // Stall mode holds until the core frees the channel
    wr(DTAM_SEL_STATUS, 32'h0010_0000);
    st(32'h0110_0000);
    wr(DTAM_SEL_RX, 32'h0bad_0008);
    fork
      wr(DTAM_SEL_RX, 32'h0bad_0009);
      begin
        repeat (8) @(posedge clock);
        chk(int_rx_data, 32'h0bad_0008);
        ev(4'h4);
      end
    join
    chk(int_rx_data, 32'h0bad_0009);
    ev(4'h4);
    int_tx_wdata = 32'h0bad_000a;
    fork
      rd(DTAM_SEL_TX);
      begin
        repeat (8) @(posedge clock);
        ev(4'h2);
      end
    join
    chk(q, 32'h0bad_000a);
    // Stall instruction write waits for complete
    p0 = pops;
    wr(DTAM_SEL_ITR, 32'hc0de_0012);
    fork
      wr(DTAM_SEL_ITR, 32'hc0de_0013);
      begin
        repeat (8) @(posedge clock);
        chk(32'(pops - p0), 32'h1);
        ev(4'h1);
      end
    join
    repeat (2) @(posedge clock);
    chk(last_ins, 32'hc0de_0013);
    ev(4'h1);
    // Fast mode replays the latched instruction
    wr(DTAM_SEL_STATUS, 32'h0020_2000);
    chk({31'h0, exec_enable}, 32'h1);
    p0 = pops;
    wr(DTAM_SEL_ITR, 32'hc0de_000b);
    repeat (2) @(posedge clock);
    chk(32'(pops - p0), 32'h0);
    wr(DTAM_SEL_RX, 32'h0bad_000c);
    repeat (2) @(posedge clock);
    chk(int_rx_data, 32'h0bad_000c);
    chk(last_ins, 32'hc0de_000b);
    st(32'h4820_2000);
    ev(4'h5);
    int_tx_wdata = 32'h0bad_000d;
    ev(4'h2);
    rd(DTAM_SEL_TX);
    chk(q, 32'h0bad_000d);
    repeat (2) @(posedge clock);
    chk(32'(pops - p0), 32'h2);
    ev(4'h1);
    precise_abort = 1'b1;
    wr(DTAM_SEL_RX, 32'h0bad_000e);
    repeat (2) @(posedge clock);
    chk(32'(pops - p0), 32'h2);
    st(32'h4920_2040);
    precise_abort = 1'b0;
    ev(4'h4);
    // Reserved code behaves as non-blocking
    wr(DTAM_SEL_STATUS, 32'h0030_0000);
    st(32'h0130_0000);
    wr(DTAM_SEL_RX, 32'h0bad_000f);
    wr(DTAM_SEL_RX, 32'h0bad_0010);
    chk(int_rx_data, 32'h0bad_000f);
    wr(DTAM_SEL_ITR, 32'hc0de_0011);
    ev(4'h8);
    st(32'h4930_0000);
    tally_and_finish();
  end
endmodule
bind dtam_access dtam_access_checker u_chk (.clock(clock), .arst_n(arst_n),
  .ext_req(ext_req), .ext_write(ext_write), .ext_sel(ext_sel), .ext_via_mem(ext_via_mem),
  .ext_ack(ext_ack), .ext_err(ext_err), .ext_rdata(ext_rdata), .os_lock(os_lock),
  .sticky_pdown(sticky_pdown), .int_rx_data(int_rx_data),
  .core_instr_valid(core_instr_valid), .exec_enable(exec_enable));
`default_nettype wire
